// *** bench/mscan_flash_model.sv ***
// Purpose: program flash seen by the scan unit
// Assumes: eight words, combinational read
// Notes: words past the array read inverted
module mscan_flash_model (
  input wire logic [15:0] i_addr,
  output logic [15:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:7];
  initial begin
    for (int w = 0; w < 8; w++) begin
      mem[w] = 16'(16'hA55A ^ (w * 16'h01F3));
    end
  end
  assign o_data = (i_addr < 16'h0008) ? mem[i_addr[2:0]] : ~mem[i_addr[2:0]];
endmodule

// *** bench/mscan_unit_assertions.sv ***
// Purpose: port assertions of the scan unit
// Assumes: one clock, async reset
// Notes: bound below
module mscan_unit_assertions (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_sleep,
  input wire logic o_flash_req,
  input wire logic o_cpu_stall,
  input wire logic o_hold_reset,
  input wire logic o_nmi
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_nmi; o_nmi |=> o_nmi; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi dropped");
  property p_hold; o_hold_reset |=> o_hold_reset; endproperty
  a_hold: assert property (p_hold) else $error("hold dropped");
  property p_nap; i_sleep [*2] |-> !o_flash_req; endproperty
  a_nap: assert property (p_nap) else $error("fetch in sleep");
  property p_gap; o_flash_req |=> !o_flash_req [*2]; endproperty
  a_gap: assert property (p_gap) else $error("fetch too soon");
  property p_dly; i_wr && i_addr == 8'h00 && i_wdata[0] && !o_cpu_stall |=> !o_flash_req [*3];
  endproperty
  a_dly: assert property (p_dly) else $error("start too early");
  property p_req; o_flash_req |-> o_cpu_stall; endproperty
  a_req: assert property (p_req) else $error("fetch unstalled");
  property p_nmc; $rose(o_nmi) |-> $past(o_cpu_stall) || $past(o_cpu_stall, 2); endproperty
  a_nmc: assert property (p_nmc) else $error("nmi without scan");
  property p_hrc; $rose(o_hold_reset) |-> $past(o_cpu_stall) || $past(o_cpu_stall, 2);
  endproperty
  a_hrc: assert property (p_hrc) else $error("hold without scan");
  c_nmi: cover property ($rose(o_nmi));
  c_hold: cover property ($rose(o_hold_reset));
  c_req: cover property (o_flash_req && o_cpu_stall);
endmodule
bind mscan_unit mscan_unit_assertions u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_sleep(i_sleep), .o_flash_req(o_flash_req),
  .o_cpu_stall(o_cpu_stall), .o_hold_reset(o_hold_reset), .o_nmi(o_nmi));

// *** bench/mscan_unit_tb.sv ***
// Purpose: self-checking bench of the scan unit
// Assumes: sections end at words 3, 5 and 7
// Notes: checksums sealed by the bench
module mscan_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_sleep = 1'b0;
  logic i_boot_scan = 1'b0, freq, stall, hold, nmi;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, s;
  logic [1:0] i_boot_sel = 2'h0;
  logic [15:0] fa, fd;
  int miscompares = 0, comparisons = 0;
  mscan_unit #(.AW(16)) uut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep(i_sleep), .i_boot_scan(i_boot_scan),
    .i_boot_sel(i_boot_sel), .i_last_program_address(16'h0007), .i_loader_end_fuse(16'h0003),
    .i_app_end_fuse(16'h0005), .i_flash_rdata(fd), .o_flash_addr(fa), .o_flash_req(freq),
    .o_cpu_stall(stall), .o_hold_reset(hold), .o_nmi(nmi));
  mscan_flash_model fl (.i_addr(fa), .o_data(fd));
  initial forever #4 i_clk = ~i_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    s = o_rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(s, e);
  endtask
  task automatic wait_idle;
    for (int n = 0; n < 300; n++) begin
      rd(8'h02);
      if (s[0] === 1'b0) break;
    end
  endtask
  function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction
  // high byte of each checksum sits first, in the last word of the section
  task automatic seal;
    logic [15:0] c;
    for (int e = 3; e <= 7; e += 2) begin
      c = 16'hFFFF;
      for (int w = 0; w < e; w++) begin
        c = crc8(crc8(c, fl.mem[w][15:8]), fl.mem[w][7:0]);
      end
      fl.mem[e] = c;
    end
  endtask
  task automatic t_scan(input logic [1:0] sel);
    wr(8'h01, {6'h00, sel});
    wr(8'h00, 8'h01);
    rc(8'h02, 8'h01);
    wait_idle();
    rc(8'h02, 8'h02);
    rc(8'h00, 8'h01);
    chk({7'h00, stall}, 8'h00);
    chk(fa[7:0], (sel == 2'h0) ? 8'h07 : ((sel == 2'h1) ? 8'h05 : 8'h03));
  endtask
  task automatic t_sleep;
    wr(8'h00, 8'h01);
    i_sleep <= 1'b1;
    repeat (30) @(posedge i_clk);
    rc(8'h02, 8'h01);
    i_sleep <= 1'b0;
    wait_idle();
    rc(8'h02, 8'h02);
  endtask
  task automatic t_stop;
    wr(8'h00, 8'h01);
    wr(8'h00, 8'h00);
    wait_idle();
    rc(8'h02, 8'h02);
    rc(8'h00, 8'h00);
  endtask
  task automatic t_soft;
    wr(8'h01, 8'h01);
    wr(8'h00, 8'h01);
    wr(8'h00, 8'h80);
    repeat (2) @(posedge i_clk);
    rc(8'h02, 8'h00);
    rc(8'h00, 8'h00);
    rc(8'h01, 8'h00);
  endtask
  task automatic t_fail;
    fl.mem[1] = fl.mem[1] ^ 16'h0100;
    wr(8'h01, 8'h02);
    wr(8'h00, 8'h03);
    wait_idle();
    rc(8'h02, 8'h00);
    chk({7'h00, nmi}, 8'h01);
    wr(8'h00, 8'h80);
    wr(8'h01, 8'h01);
    rc(8'h00, 8'h03);
    rc(8'h01, 8'h02);
  endtask
  task automatic t_boot;
    i_boot_scan <= 1'b1;
    i_boot_sel <= 2'h2;
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rc(8'h00, 8'h01);
    rc(8'h01, 8'h12);
    wait_idle();
    chk({7'h00, hold}, 8'h01);
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    seal();
    rc(8'h02, 8'h02);
    rc(8'h05, 8'h00);
    for (int k = 0; k < 3; k++) begin
      t_scan(2'(k));
    end
    t_sleep();
    t_stop();
    t_soft();
    t_fail();
    t_boot();
    wrap_up();
  end
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end
endmodule

// *** rtl/mscan_pkg.sv ***
// Purpose: types of the memory scan unit
// Assumes: constants live in mscan_regs.svh
// Notes: none
package mscan_pkg;
  typedef enum logic [2:0] {
    MSCAN_IDLE = 3'b000,
    MSCAN_DELAY = 3'b001,
    MSCAN_FETCH = 3'b010,
    MSCAN_WAIT = 3'b011,
    MSCAN_BYTE0 = 3'b100,
    MSCAN_BYTE1 = 3'b101
  } mscan_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mscan_bus_t;

  typedef struct packed {
    mscan_state_t st;
    logic [1:0] dly;
    logic [1:0] div;
    logic [1:0] byte_idx;
    logic [15:0] crc;
    logic [15:0] word;
    logic [15:0] stored;
    logic enable;
    logic nmi_trigger_enable;
    logic nmi;
    logic [1:0] policy;
    logic [1:0] sel;
    logic busy;
    logic pass;
    logic stop_at_end;
    logic boot_scan;
    logic hold_rst;
    logic rd_pend;
    logic [7:0] rdata;
    logic [15:0] faddr;
    logic freq;
    logic stall;
    logic soft_pend;
  } mscan_state_vec_t;
endpackage

// *** rtl/mscan_regs.svh ***
// Purpose: offsets, fields, reset values and timing counts of the memory scan unit
// Assumes: registers reached over a plain byte-wide port
// Notes: bit and field positions below are the register layout
`ifndef MSCAN_REGS_SVH
`define MSCAN_REGS_SVH
`define MSCAN_OFS_CTRL_PRI 2'h0
`define MSCAN_OFS_CTRL_SRC 2'h1
`define MSCAN_OFS_STATUS 2'h2
`define MSCAN_BIT_ENABLE 0
`define MSCAN_BIT_NMI_TRIGGER_ENABLE 1
`define MSCAN_BIT_SOFTRST 7
`define MSCAN_BIT_BUSY 0
`define MSCAN_BIT_PASS 1
`define MSCAN_SEL_LSB 0
`define MSCAN_POL_LSB 4
`define MSCAN_POL_PRIORITY 2'h0
`define MSCAN_SEL_ALL 2'h0
`define MSCAN_SEL_LDR_APP 2'h1
`define MSCAN_SEL_LDR 2'h2
`define MSCAN_CRC_POLY 16'h1021
`define MSCAN_CRC_INIT 16'hFFFF
`define MSCAN_START_DELAY 2'h3
`define MSCAN_FETCH_DIV 2'h3
`define MSCAN_NMI_VECTOR 8'h00
`endif

// *** rtl/mscan_unit.sv ***
// Purpose: background crc-16 check of a program flash section
// Assumes: flash answers a word request in the same cycle (combinational read data)
// Notes: section end addresses come in as word addresses from the fuse logic
`include "mscan_regs.svh"
module mscan_unit #(
  parameter int AW = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_sleep,
  input wire logic i_boot_scan,
  input wire logic [1:0] i_boot_sel,
  input wire logic [AW-1:0] i_last_program_address,
  input wire logic [AW-1:0] i_loader_end_fuse,
  input wire logic [AW-1:0] i_app_end_fuse,
  input wire logic [15:0] i_flash_rdata,
  output logic [AW-1:0] o_flash_addr,
  output logic o_flash_req,
  output logic o_cpu_stall,
  output logic o_hold_reset,
  output logic o_nmi
);
  mscan_pkg::mscan_state_vec_t s_q, s_d;
  logic [AW-1:0] last_word;
  logic [7:0] cur_byte;
  logic [15:0] crc_next;
  logic wr_pri, wr_src, at_last;

  // word address of the last word of the chosen section
  always_comb begin
    unique case (s_q.sel)
      `MSCAN_SEL_LDR_APP: last_word = i_app_end_fuse;
      `MSCAN_SEL_LDR: last_word = i_loader_end_fuse;
      default: last_word = i_last_program_address;
    endcase
  end

  // big-endian byte order within a word keeps byte 0 first
  assign cur_byte = (s_q.byte_idx[0]) ? s_q.word[7:0] : s_q.word[15:8];
  assign at_last = (s_q.faddr[AW-1:0] == last_word);

  // bitwise ccitt step, msb first
  always_comb begin
    logic [15:0] c;
    c = s_q.crc;
    for (int b = 7; b >= 0; b--) begin
      if (c[15] ^ cur_byte[b]) begin
        c = {c[14:0], 1'b0} ^ `MSCAN_CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    crc_next = c;
  end

  assign wr_pri = i_wr && i_addr == {6'h00, `MSCAN_OFS_CTRL_PRI};
  assign wr_src = i_wr && i_addr == {6'h00, `MSCAN_OFS_CTRL_SRC};

  always_comb begin
    s_d = s_q;
    s_d.freq = 1'b0;
    s_d.rd_pend = 1'b0;
    s_d.rdata = 8'h00;
    // soft reset clears registers one cycle after the strobe
    if (s_q.soft_pend) begin
      s_d.soft_pend = 1'b0;
      s_d.enable = 1'b0;
      s_d.policy = 2'h0;
      s_d.sel = 2'h0;
      s_d.busy = 1'b0;
      s_d.pass = 1'b0;
      s_d.stop_at_end = 1'b0;
      s_d.st = mscan_pkg::MSCAN_IDLE;
    end
    if (wr_pri && !s_q.nmi) begin
      if (i_wdata[`MSCAN_BIT_SOFTRST] && (!s_q.nmi_trigger_enable || !s_q.busy)) begin
        s_d.soft_pend = 1'b1;
      end
      if (i_wdata[`MSCAN_BIT_NMI_TRIGGER_ENABLE] && !s_q.busy) begin
        s_d.nmi_trigger_enable = 1'b1;
      end
      if (i_wdata[`MSCAN_BIT_ENABLE]) begin
        s_d.enable = 1'b1;
        s_d.stop_at_end = 1'b0;
        s_d.pass = 1'b0;
        s_d.busy = 1'b1;
        s_d.dly = `MSCAN_START_DELAY;
        s_d.st = mscan_pkg::MSCAN_DELAY;
      end else if (s_q.busy) begin
        s_d.stop_at_end = 1'b1;
      end else begin
        s_d.enable = 1'b0;
      end
    end
    if (wr_src && !s_q.busy && !s_q.nmi) begin
      s_d.policy = i_wdata[`MSCAN_POL_LSB +: 2];
      s_d.sel = i_wdata[`MSCAN_SEL_LSB +: 2];
    end
    if (i_rd) begin
      s_d.rd_pend = 1'b1;
      unique case (i_addr)
        {6'h00, `MSCAN_OFS_CTRL_PRI}: s_d.rdata = {6'h00, s_q.nmi_trigger_enable, s_q.enable};
        {6'h00, `MSCAN_OFS_CTRL_SRC}: s_d.rdata = {2'h0, s_q.policy, 2'h0, s_q.sel};
        // pass masked while busy
        {6'h00, `MSCAN_OFS_STATUS}: s_d.rdata = {6'h00, s_q.pass & ~s_q.busy, s_q.busy};
        default: s_d.rdata = 8'h00;
      endcase
    end
    // sleep freezes the sequencer in place, including the start delay
    if (!i_sleep && !s_q.soft_pend) begin
      unique case (s_q.st)
        mscan_pkg::MSCAN_IDLE: ;
        mscan_pkg::MSCAN_DELAY: begin
          if (s_q.dly == 2'h1) begin
            s_d.st = mscan_pkg::MSCAN_FETCH;
            s_d.crc = `MSCAN_CRC_INIT;
            s_d.faddr = '0;
            s_d.byte_idx = 2'h0;
            s_d.div = 2'h0;
          end else begin
            s_d.dly = s_q.dly - 2'h1;
          end
        end
        mscan_pkg::MSCAN_FETCH: begin
          if (s_q.div == `MSCAN_FETCH_DIV - 2'h1) begin
            s_d.freq = 1'b1;
            s_d.word = i_flash_rdata;
            s_d.div = 2'h0;
            s_d.st = mscan_pkg::MSCAN_BYTE0;
          end else begin
            s_d.div = s_q.div + 2'h1;
          end
        end
        mscan_pkg::MSCAN_BYTE0: begin
          s_d.crc = crc_next;
          s_d.byte_idx = 2'h1;
          s_d.st = mscan_pkg::MSCAN_BYTE1;
        end
        mscan_pkg::MSCAN_BYTE1: begin
          s_d.crc = crc_next;
          s_d.byte_idx = 2'h0;
          if (at_last) begin
            // crc over data plus stored checksum leaves zero on a match
            s_d.busy = 1'b0;
            s_d.pass = (crc_next == 16'h0000);
            if (crc_next != 16'h0000) begin
              s_d.pass = 1'b0;
              if (s_q.nmi_trigger_enable) s_d.nmi = 1'b1;
              if (s_q.boot_scan) s_d.hold_rst = 1'b1;
            end
            s_d.boot_scan = 1'b0;
            if (s_q.stop_at_end) s_d.enable = 1'b0;
            s_d.stop_at_end = 1'b0;
            s_d.st = mscan_pkg::MSCAN_IDLE;
          end else begin
            s_d.faddr = s_q.faddr + 1'b1;
            s_d.st = mscan_pkg::MSCAN_FETCH;
          end
        end
        default: s_d.st = mscan_pkg::MSCAN_IDLE;
      endcase
    end
    // reset-time scan is captured on the first cycle after release
    if (s_q.boot_scan && s_q.st == mscan_pkg::MSCAN_IDLE && !s_q.busy && !s_q.hold_rst) begin
      if (i_boot_scan) begin
        s_d.enable = 1'b1;
        s_d.policy = 2'h1;
        s_d.sel = i_boot_sel;
        s_d.busy = 1'b1;
        s_d.pass = 1'b0;
        s_d.dly = 2'h1;
        s_d.st = mscan_pkg::MSCAN_DELAY;
      end else begin
        s_d.boot_scan = 1'b0;
      end
    end
    // processor held off for the priority check except during the start delay, and for the whole reset-time scan, its delay included
    s_d.stall = s_d.busy && s_d.policy == `MSCAN_POL_PRIORITY && s_d.st != mscan_pkg::MSCAN_DELAY;
    if (s_q.boot_scan) s_d.stall = 1'b1;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.st <= mscan_pkg::MSCAN_IDLE;
      s_q.crc <= `MSCAN_CRC_INIT;
      s_q.pass <= 1'b1;
      s_q.boot_scan <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_flash_addr = s_q.faddr;
  assign o_flash_req = s_q.freq;
  assign o_cpu_stall = s_q.stall;
  assign o_hold_reset = s_q.hold_rst;
  assign o_nmi = s_q.nmi;
endmodule
